// ==== common/t16w_pkg.sv ====
// Constants and types shared by the 16-bit waveform timer.
package t16w_pkg;
	// =========================================================
	// Register map.
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_CNT  = 3'h1;
	localparam logic [2:0] ADDR_CMPA = 3'h2;
	localparam logic [2:0] ADDR_CMPB = 3'h3;
	localparam logic [2:0] ADDR_CAP  = 3'h4;
	localparam logic [2:0] ADDR_FLG  = 3'h5;
	// Control field positions.
	localparam int WGM_LSB = 0;
	localparam int OMA_LSB = 4;
	localparam int OMB_LSB = 6;
	localparam int PS_LSB  = 8;
	localparam int DIRA    = 11;
	localparam int DIRB    = 12;
	// Flag bit positions.
	localparam int FLG_OVF  = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAP  = 3;
	// =========================================================
	// Waveform selector values.
	localparam logic [3:0] WGM_NORMAL  = 4'h0;
	localparam logic [3:0] WGM_PC_8    = 4'h1;
	localparam logic [3:0] WGM_PC_9    = 4'h2;
	localparam logic [3:0] WGM_PC_10   = 4'h3;
	localparam logic [3:0] WGM_CTC_A   = 4'h4;
	localparam logic [3:0] WGM_FP_8    = 4'h5;
	localparam logic [3:0] WGM_FP_9    = 4'h6;
	localparam logic [3:0] WGM_FP_10   = 4'h7;
	localparam logic [3:0] WGM_PC_CAP  = 4'ha;
	localparam logic [3:0] WGM_PC_A    = 4'hb;
	localparam logic [3:0] WGM_CTC_CAP = 4'hc;
	localparam logic [3:0] WGM_FP_CAP  = 4'he;
	localparam logic [3:0] WGM_FP_A    = 4'hf;
	localparam logic [15:0] TOP_8   = 16'h00ff;
	localparam logic [15:0] TOP_9   = 16'h01ff;
	localparam logic [15:0] TOP_10  = 16'h03ff;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] ZERO16  = 16'h0000;
	// Output modes.
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_NONINV = 2'h2;
	localparam logic [1:0] OM_INV    = 2'h3;
	// Prescaler selections and their divide-minus-one counts.
	localparam logic [2:0] PS_STOP = 3'h0;
	localparam logic [2:0] PS_1    = 3'h1;
	localparam logic [2:0] PS_8    = 3'h2;
	localparam logic [2:0] PS_64   = 3'h3;
	localparam logic [2:0] PS_256  = 3'h4;
	localparam logic [9:0] DIV1_M1    = 10'h000;
	localparam logic [9:0] DIV8_M1    = 10'h007;
	localparam logic [9:0] DIV64_M1   = 10'h03f;
	localparam logic [9:0] DIV256_M1  = 10'h0ff;
	localparam logic [9:0] DIV1024_M1 = 10'h3ff;
	localparam int NCH = 2;
	typedef enum logic [1:0] {
		KIND_NORMAL,
		KIND_CTC,
		KIND_FAST,
		KIND_PHASE
	} t16w_kind_e;
endpackage : t16w_pkg

// ==== hdl/t16w_prescaler.sv ====
// Prescaler that turns the system clock into a timer tick enable.
`timescale 1ns/1ps
`default_nettype none
module t16w_prescaler (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic [2:0] i_sel,
	output logic            o_tick
);
	typedef struct packed {
		logic [9:0] div;
		logic       tick;
	} t16w_ps_s;
	t16w_ps_s s_q;
	t16w_ps_s s_d;
	logic [9:0] lim;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		case (i_sel)
			t16w_pkg::PS_1:   lim = t16w_pkg::DIV1_M1;
			t16w_pkg::PS_8:   lim = t16w_pkg::DIV8_M1;
			t16w_pkg::PS_64:  lim = t16w_pkg::DIV64_M1;
			t16w_pkg::PS_256: lim = t16w_pkg::DIV256_M1;
			default:          lim = t16w_pkg::DIV1024_M1;
		endcase
		if (i_sel == t16w_pkg::PS_STOP) begin
			s_d.div = 10'h000;
		end else if (s_q.div >= lim) begin
			s_d.div = 10'h000;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 10'h001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tick = s_q.tick;
endmodule : t16w_prescaler
`default_nettype wire

// ==== hdl/t16w_channel.sv ====
// One compare channel: buffered compare value, match and waveform bit.
`timescale 1ns/1ps
`default_nettype none
module t16w_channel (
	input  wire logic               i_clk,
	input  wire logic               i_rst_b,
	input  wire logic               i_tick,
	input  wire t16w_pkg::t16w_kind_e i_kind,
	input  wire logic               i_wr,
	input  wire logic [15:0]        i_wdata,
	input  wire logic               i_load,
	input  wire logic [15:0]        i_count,
	input  wire logic               i_at_top,
	input  wire logic               i_down,
	input  wire logic [1:0]         i_out_mode,
	input  wire logic               i_toggle_ok,
	output logic [15:0]             o_active,
	output logic [15:0]             o_buffer,
	output logic                    o_match,
	output logic                    o_wave
);
	typedef struct packed {
		logic [15:0] active;
		logic [15:0] buffer;
		logic        wave;
	} t16w_ch_s;
	t16w_ch_s s_q;
	t16w_ch_s s_d;
	logic     pwm;

	assign pwm = (i_kind == t16w_pkg::KIND_FAST) || (i_kind == t16w_pkg::KIND_PHASE);
	assign o_match = i_tick && (i_count == s_q.active);

	always_comb begin
		s_d = s_q;
		if (i_load) begin
			s_d.active = s_q.buffer;
		end
		if (i_wr) begin
			s_d.buffer = i_wdata;
			// Outside PWM a write takes effect at once, so a low top can be missed.
			if (!pwm) begin
				s_d.active = i_wdata;
			end
		end
		case (i_kind)
			t16w_pkg::KIND_FAST: begin
				if (i_tick && i_out_mode == t16w_pkg::OM_NONINV) begin
					if (i_at_top) begin
						s_d.wave = 1'b0;
					end else if (o_match) begin
						s_d.wave = 1'b1;
					end
				end else if (i_tick && i_out_mode == t16w_pkg::OM_INV) begin
					if (i_at_top) begin
						s_d.wave = 1'b1;
					end else if (o_match) begin
						s_d.wave = 1'b0;
					end
				end else if (o_match && i_toggle_ok && i_out_mode == t16w_pkg::OM_TOGGLE) begin
					s_d.wave = ~s_q.wave;
				end
			end
			t16w_pkg::KIND_PHASE: begin
				if (o_match) begin
					case (i_out_mode)
						t16w_pkg::OM_NONINV: s_d.wave = i_down;
						t16w_pkg::OM_INV:    s_d.wave = ~i_down;
						t16w_pkg::OM_TOGGLE: s_d.wave = i_toggle_ok ? ~s_q.wave : s_q.wave;
						default:             s_d.wave = s_q.wave;
					endcase
				end
			end
			default: begin
				if (o_match) begin
					case (i_out_mode)
						t16w_pkg::OM_TOGGLE: s_d.wave = ~s_q.wave;
						t16w_pkg::OM_NONINV: s_d.wave = 1'b0;
						t16w_pkg::OM_INV:    s_d.wave = 1'b1;
						default:             s_d.wave = s_q.wave;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_active = s_q.active;
	assign o_buffer = s_q.buffer;
	assign o_wave = s_q.wave;
endmodule : t16w_channel
`default_nettype wire

// ==== hdl/t16w_timer.sv ====
// Top of the 16-bit waveform timer: counter, modes, flags, registers, pins.
`timescale 1ns/1ps
`default_nettype none
module t16w_timer (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic [2:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [15:0]      o_rdata,
	output logic             o_pin_a,
	output logic             o_pin_a_oe_b,
	output logic             o_pin_b,
	output logic             o_pin_b_oe_b
);
	// =========================================================
	// State.
	typedef struct packed {
		logic [3:0]  wgm;
		logic [1:0]  om_a;
		logic [1:0]  om_b;
		logic [2:0]  ps;
		logic        dir_a;
		logic        dir_b;
		logic [15:0] count;
		logic        down;
		logic [15:0] capture;
		logic [3:0]  flags;
		logic [15:0] rdata;
		logic        pin_a;
		logic        oe_a_b;
		logic        pin_b;
		logic        oe_b_b;
	} t16w_top_s;

	localparam int NCH_W = t16w_pkg::NCH;

	t16w_top_s            s_q;
	t16w_top_s            s_d;
	t16w_pkg::t16w_kind_e kind;
	logic                 tick;
	logic [15:0]          top_val;
	logic [15:0]          wmask;
	logic                 top_is_cap;
	logic                 at_top;
	logic                 load;
	logic [NCH_W-1:0]     ch_wr;
	logic [1:0]           ch_om [2];
	logic [15:0]          ch_act [2];
	logic [15:0]          ch_buf [2];
	logic [1:0]           ch_match;
	logic [1:0]           ch_wave;
	logic [1:0]           ch_tog;

	// =========================================================
	// Timer tick.
	t16w_prescaler u_ps (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_sel   (s_q.ps),
		.o_tick  (tick)
	);

	// =========================================================
	// Mode decode: kind of counting, source of top, compare mask.
	always_comb begin
		kind = t16w_pkg::KIND_NORMAL;
		top_val = t16w_pkg::CNT_MAX;
		wmask = t16w_pkg::CNT_MAX;
		top_is_cap = 1'b0;
		case (s_q.wgm)
			t16w_pkg::WGM_CTC_A: begin
				kind = t16w_pkg::KIND_CTC;
				top_val = ch_act[0];
			end
			t16w_pkg::WGM_CTC_CAP: begin
				kind = t16w_pkg::KIND_CTC;
				top_val = s_q.capture;
				top_is_cap = 1'b1;
			end
			t16w_pkg::WGM_FP_8: begin
				kind = t16w_pkg::KIND_FAST;
				top_val = t16w_pkg::TOP_8;
				wmask = t16w_pkg::TOP_8;
			end
			t16w_pkg::WGM_FP_9: begin
				kind = t16w_pkg::KIND_FAST;
				top_val = t16w_pkg::TOP_9;
				wmask = t16w_pkg::TOP_9;
			end
			t16w_pkg::WGM_FP_10: begin
				kind = t16w_pkg::KIND_FAST;
				top_val = t16w_pkg::TOP_10;
				wmask = t16w_pkg::TOP_10;
			end
			t16w_pkg::WGM_FP_CAP: begin
				kind = t16w_pkg::KIND_FAST;
				top_val = s_q.capture;
				top_is_cap = 1'b1;
			end
			t16w_pkg::WGM_FP_A: begin
				kind = t16w_pkg::KIND_FAST;
				top_val = ch_act[0];
			end
			t16w_pkg::WGM_PC_8: begin
				kind = t16w_pkg::KIND_PHASE;
				top_val = t16w_pkg::TOP_8;
				wmask = t16w_pkg::TOP_8;
			end
			t16w_pkg::WGM_PC_9: begin
				kind = t16w_pkg::KIND_PHASE;
				top_val = t16w_pkg::TOP_9;
				wmask = t16w_pkg::TOP_9;
			end
			t16w_pkg::WGM_PC_10: begin
				kind = t16w_pkg::KIND_PHASE;
				top_val = t16w_pkg::TOP_10;
				wmask = t16w_pkg::TOP_10;
			end
			t16w_pkg::WGM_PC_CAP: begin
				kind = t16w_pkg::KIND_PHASE;
				top_val = s_q.capture;
				top_is_cap = 1'b1;
			end
			t16w_pkg::WGM_PC_A: begin
				kind = t16w_pkg::KIND_PHASE;
				top_val = ch_act[0];
			end
			default: begin
				kind = t16w_pkg::KIND_NORMAL;
			end
		endcase
	end

	// Top is only reached on the rising side; a top written below the count
	// is passed by and caught again after the wrap through zero.
	assign at_top = tick && !s_q.down && (s_q.count == top_val);
	assign load = at_top && ((kind == t16w_pkg::KIND_FAST) || (kind == t16w_pkg::KIND_PHASE));

	// =========================================================
	// Compare channels.
	assign ch_om[0] = s_q.om_a;
	assign ch_om[1] = s_q.om_b;
	assign ch_tog[0] = (s_q.wgm == t16w_pkg::WGM_FP_A) || (s_q.wgm == t16w_pkg::WGM_PC_A);
	assign ch_tog[1] = 1'b0;

	generate
		for (genvar i = 0; i < NCH_W; i++) begin : g_ch
			assign ch_wr[i] = i_wr && (i_addr == (t16w_pkg::ADDR_CMPA + 3'(i)));
			t16w_channel u_ch (
				.i_clk       (i_clk),
				.i_rst_b     (i_rst_b),
				.i_tick      (tick),
				.i_kind      (kind),
				.i_wr        (ch_wr[i]),
				.i_wdata     (i_wdata & wmask),
				.i_load      (load),
				.i_count     (s_q.count),
				.i_at_top    (at_top),
				.i_down      (s_q.down),
				.i_out_mode  (ch_om[i]),
				.i_toggle_ok (ch_tog[i]),
				.o_active    (ch_act[i]),
				.o_buffer    (ch_buf[i]),
				.o_match     (ch_match[i]),
				.o_wave      (ch_wave[i])
			);
		end
	endgenerate

	// =========================================================
	// Counter, flags, register writes and reads.
	always_comb begin
		logic [3:0] fset;
		logic [3:0] fclr;
		fset = 4'h0;
		fclr = 4'h0;
		s_d = s_q;
		s_d.rdata = t16w_pkg::ZERO16;

		if (tick) begin
			case (kind)
				t16w_pkg::KIND_CTC: begin
					if (at_top) begin
						s_d.count = t16w_pkg::ZERO16;
					end else begin
						s_d.count = s_q.count + 16'h0001;
					end
					if (s_q.count == t16w_pkg::CNT_MAX) begin
						fset[t16w_pkg::FLG_OVF] = 1'b1;
					end
				end
				t16w_pkg::KIND_FAST: begin
					if (at_top) begin
						s_d.count = t16w_pkg::ZERO16;
						fset[t16w_pkg::FLG_OVF] = 1'b1;
					end else begin
						s_d.count = s_q.count + 16'h0001;
					end
				end
				t16w_pkg::KIND_PHASE: begin
					if (!s_q.down) begin
						if (at_top) begin
							s_d.down = 1'b1;
							s_d.count = s_q.count - 16'h0001;
						end else begin
							s_d.count = s_q.count + 16'h0001;
						end
					end else if (s_q.count == t16w_pkg::ZERO16) begin
						s_d.down = 1'b0;
						s_d.count = 16'h0001;
						fset[t16w_pkg::FLG_OVF] = 1'b1;
					end else begin
						s_d.count = s_q.count - 16'h0001;
					end
				end
				default: begin
					s_d.count = s_q.count + 16'h0001;
					if (s_q.count == t16w_pkg::CNT_MAX) begin
						fset[t16w_pkg::FLG_OVF] = 1'b1;
					end
				end
			endcase
		end
		if (kind != t16w_pkg::KIND_PHASE) begin
			s_d.down = 1'b0;
		end

		// With compare A as top its own match marks top; capture needs a term.
		fset[t16w_pkg::FLG_CMPA] = ch_match[0];
		fset[t16w_pkg::FLG_CMPB] = ch_match[1];
		if (at_top && top_is_cap) begin
			fset[t16w_pkg::FLG_CAP] = 1'b1;
		end

		if (i_wr) begin
			if (i_addr == t16w_pkg::ADDR_CTRL) begin
				s_d.wgm = i_wdata[t16w_pkg::WGM_LSB +: 4];
				s_d.om_a = i_wdata[t16w_pkg::OMA_LSB +: 2];
				s_d.om_b = i_wdata[t16w_pkg::OMB_LSB +: 2];
				s_d.ps = i_wdata[t16w_pkg::PS_LSB +: 3];
				s_d.dir_a = i_wdata[t16w_pkg::DIRA];
				s_d.dir_b = i_wdata[t16w_pkg::DIRB];
			end else if (i_addr == t16w_pkg::ADDR_CNT) begin
				s_d.count = i_wdata;
			end else if (i_addr == t16w_pkg::ADDR_CAP) begin
				s_d.capture = i_wdata;
			end else if (i_addr == t16w_pkg::ADDR_FLG) begin
				fclr = i_wdata[3:0];
			end
		end
		// A flag raised in the cycle it is cleared survives.
		s_d.flags = (s_q.flags & ~fclr) | fset;

		if (i_rd) begin
			if (i_addr == t16w_pkg::ADDR_CTRL) begin
				s_d.rdata[t16w_pkg::WGM_LSB +: 4] = s_q.wgm;
				s_d.rdata[t16w_pkg::OMA_LSB +: 2] = s_q.om_a;
				s_d.rdata[t16w_pkg::OMB_LSB +: 2] = s_q.om_b;
				s_d.rdata[t16w_pkg::PS_LSB +: 3] = s_q.ps;
				s_d.rdata[t16w_pkg::DIRA] = s_q.dir_a;
				s_d.rdata[t16w_pkg::DIRB] = s_q.dir_b;
			end else if (i_addr == t16w_pkg::ADDR_CNT) begin
				s_d.rdata = s_q.count;
			end else if (i_addr == t16w_pkg::ADDR_CMPA) begin
				s_d.rdata = ch_buf[0];
			end else if (i_addr == t16w_pkg::ADDR_CMPB) begin
				s_d.rdata = ch_buf[1];
			end else if (i_addr == t16w_pkg::ADDR_CAP) begin
				s_d.rdata = s_q.capture;
			end else if (i_addr == t16w_pkg::ADDR_FLG) begin
				s_d.rdata[3:0] = s_q.flags;
			end
		end

		// Pins: driven only with the direction bit set and a mode selected.
		s_d.pin_a = ch_wave[0];
		s_d.pin_b = ch_wave[1];
		s_d.oe_a_b = ~(s_q.dir_a && (s_q.om_a != t16w_pkg::OM_OFF));
		s_d.oe_b_b = ~(s_q.dir_b && (s_q.om_b != t16w_pkg::OM_OFF));
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
			s_q.oe_a_b <= 1'b1;
			s_q.oe_b_b <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_pin_a = s_q.pin_a;
	assign o_pin_a_oe_b = s_q.oe_a_b;
	assign o_pin_b = s_q.pin_b;
	assign o_pin_b_oe_b = s_q.oe_b_b;
endmodule : t16w_timer
`default_nettype wire

// ==== test/t16w_timer_properties.sv ====
// Port-level checker for the 16-bit waveform timer.
`timescale 1ns/1ps
`default_nettype none
module t16w_timer_properties (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic [2:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        o_pin_a,
	input wire logic        o_pin_a_oe_b,
	input wire logic        o_pin_b,
	input wire logic        o_pin_b_oe_b
);
	// ===========================================================
	// Shadows of software writes; the pins are judged against them.
	logic [15:0] ctrl_q;
	logic [15:0] cap_q;
	logic [15:0] cmpa_q;
	logic [3:0]  quiet_q;
	logic        a_en;
	logic        b_en;
	assign a_en = ctrl_q[11] && (ctrl_q[5:4] != 2'h0);
	assign b_en = ctrl_q[12] && (ctrl_q[7:6] != 2'h0);
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q  <= 16'h0000;
			cap_q   <= 16'h0000;
			cmpa_q  <= 16'h0000;
			quiet_q <= 4'h0;
		end else if (i_wr) begin
			quiet_q <= 4'h0;
			if (i_addr == t16w_pkg::ADDR_CTRL) ctrl_q <= i_wdata;
			if (i_addr == t16w_pkg::ADDR_CAP) cap_q <= i_wdata;
			if (i_addr == t16w_pkg::ADDR_CMPA) cmpa_q <= i_wdata;
		end else if (quiet_q != 4'hf) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end
	// ===========================================================
	// Properties.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_rd_cap;
		i_rd && (i_addr == t16w_pkg::ADDR_CAP);
	endsequence
	sequence s_ctc_settled;
		(ctrl_q[10:0] == 11'h114) && (cmpa_q == 16'h0000) && (quiet_q > 4'h8);
	endsequence
	property p_rd_idle;
		!i_rd |=> o_rdata == 16'h0000;
	endproperty
	property p_cap_back;
		s_rd_cap |=> o_rdata == cap_q;
	endproperty
	property p_ctrl_back;
		i_rd && (i_addr == t16w_pkg::ADDR_CTRL) |=> o_rdata[12:0] == ctrl_q[12:0];
	endproperty
	property p_reset_pins;
		$rose(i_rst_b) |-> o_pin_a_oe_b && o_pin_b_oe_b && !o_pin_a && !o_pin_b;
	endproperty
	property p_oe_a_off;
		!a_en && !$past(a_en) |-> o_pin_a_oe_b;
	endproperty
	property p_oe_b_off;
		!b_en && !$past(b_en) |-> o_pin_b_oe_b;
	endproperty
	property p_oe_on;
		a_en && $past(a_en) && b_en && $past(b_en) |-> !o_pin_a_oe_b && !o_pin_b_oe_b;
	endproperty
	property p_ctc_toggle;
		s_ctc_settled |-> o_pin_a != $past(o_pin_a);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	a_cap_back: assert property (p_cap_back) else $error("top readback wrong");
	a_ctrl_back: assert property (p_ctrl_back) else $error("ctrl readback wrong");
	a_reset_pins: assert property (p_reset_pins) else $error("pins not reset");
	a_oe_a_off: assert property (p_oe_a_off) else $error("pin a driven");
	a_oe_b_off: assert property (p_oe_b_off) else $error("pin b driven");
	a_oe_on: assert property (p_oe_on) else $error("pins not driven");
	a_ctc_toggle: assert property (p_ctc_toggle) else $error("no toggle");
endmodule : t16w_timer_properties
`default_nettype wire

// ==== test/t16w_timer_tb.sv ====
// Self-checking bench for the 16-bit waveform timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module t16w_timer_tb;
	logic        i_clk, i_rst_b, i_wr, i_rd;
	logic        o_pin_a, o_pin_a_oe_b, o_pin_b, o_pin_b_oe_b;
	logic [2:0]  i_addr;
	logic [15:0] i_wdata, o_rdata, v, m;
	int          err_total, n_tests, k;
	int          dv[5] = '{1, 8, 64, 256, 1024};
	t16w_timer dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_a(o_pin_a),
		.o_pin_a_oe_b(o_pin_a_oe_b), .o_pin_b(o_pin_b), .o_pin_b_oe_b(o_pin_b_oe_b));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// ===========================================================
	// Bus and measurement helpers.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask : rd
	function automatic logic [15:0] ctl(logic [3:0] w, logic [1:0] a, logic [1:0] b,
		logic [2:0] p);
		return {3'h0, 2'h3, p, b, a, w};
	endfunction : ctl
	// A read every seven cycles is coprime with every period used, so each count is seen.
	task automatic max_cnt(input int n, output logic [15:0] mx);
		logic [15:0] c;
		mx = 16'h0000;
		for (int i = 0; i < n; i++) begin
			rd(t16w_pkg::ADDR_CNT, c);
			if (c > mx) mx = c;
			repeat (5) @(posedge i_clk);
		end
	endtask : max_cnt
	task automatic ones_b(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge i_clk);
			c += int'(o_pin_b === 1'b1);
		end
	endtask : ones_b
	task automatic close_out();
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	// ===========================================================
	// Scenarios.
	task automatic t_reset();
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), v);
			`CHK(v, 16'h0000);
		end
		`CHK({o_pin_a_oe_b, o_pin_b_oe_b}, 2'b11);
	endtask : t_reset
	task automatic t_ctc();
		wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_CTC_A, 2'h1, 2'h0, 3'h1));
		wr(t16w_pkg::ADDR_CMPA, 16'h0005);
		wr(t16w_pkg::ADDR_CMPB, 16'h0002);
		wr(t16w_pkg::ADDR_CNT, 16'h0000);
		wr(t16w_pkg::ADDR_FLG, 16'h000f);
		repeat (20) @(posedge i_clk);
		rd(t16w_pkg::ADDR_FLG, v);
		`CHK(v[3:0], 4'h6);
		max_cnt(20, m);
		`CHK(m, 16'h0005);
		wr(t16w_pkg::ADDR_CNT, 16'hfff0);
		repeat (4) @(posedge i_clk);
		rd(t16w_pkg::ADDR_CNT, v);
		`CHK(v > 16'hfff0, 1'b1);
		repeat (20) @(posedge i_clk);
		rd(t16w_pkg::ADDR_FLG, v);
		`CHK(v[0], 1'b1);
		wr(t16w_pkg::ADDR_CMPA, 16'h0000);
		wr(t16w_pkg::ADDR_CNT, 16'h0000);
		repeat (12) @(posedge i_clk);
		@(negedge i_clk);
		v[0] = o_pin_a;
		@(negedge i_clk);
		`CHK(o_pin_a, ~v[0]);
		wr(t16w_pkg::ADDR_CTRL, 16'h0114);
		repeat (3) @(posedge i_clk);
		`CHK(o_pin_a_oe_b, 1'b1);
		wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_CTC_CAP, 2'h0, 2'h0, 3'h1));
		wr(t16w_pkg::ADDR_CAP, 16'h0004);
		wr(t16w_pkg::ADDR_CMPA, 16'h0002);
		wr(t16w_pkg::ADDR_CNT, 16'h0000);
		wr(t16w_pkg::ADDR_FLG, 16'h000f);
		repeat (20) @(posedge i_clk);
		rd(t16w_pkg::ADDR_FLG, v);
		`CHK(v[3:0], 4'he);
	endtask : t_ctc
	task automatic t_prescale();
		wr(t16w_pkg::ADDR_CMPA, 16'hffff);
		for (int p = 0; p < 5; p++) begin
			wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_CTC_A, 2'h0, 2'h0, 3'(p + 1)));
			wr(t16w_pkg::ADDR_CNT, 16'h0000);
			repeat (10 * dv[p] - 1) @(posedge i_clk);
			rd(t16w_pkg::ADDR_CNT, v);
			`CHK(v >= 16'h0009 && v <= 16'h000b, 1'b1);
		end
	endtask : t_prescale
	task automatic t_fast();
		wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_FP_8, 2'h2, 2'h2, 3'h1));
		wr(t16w_pkg::ADDR_CMPB, 16'h1234);
		rd(t16w_pkg::ADDR_CMPB, v);
		`CHK(v, 16'h0034);
		max_cnt(300, m);
		`CHK(m, t16w_pkg::TOP_8);
		wr(t16w_pkg::ADDR_CMPA, 16'h0003);
		wr(t16w_pkg::ADDR_CMPB, 16'h0000);
		repeat (300) @(posedge i_clk);
		for (int i = 0; i < 2; i++) begin
			wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_FP_A, 2'h2, 2'(2 + i), 3'h1));
			// A count left above the new top would run the long way round through the wrap.
			if (i == 0) wr(t16w_pkg::ADDR_CNT, 16'h0000);
			repeat (8) @(posedge i_clk);
			ones_b(40, k);
			`CHK(k, (i == 1) ? 10 : 30);
		end
		wr(t16w_pkg::ADDR_FLG, 16'h000f);
		repeat (8) @(posedge i_clk);
		rd(t16w_pkg::ADDR_FLG, v);
		`CHK(v[2:0], 3'h7);
		wr(t16w_pkg::ADDR_CMPA, 16'h0007);
		repeat (20) @(posedge i_clk);
		wr(t16w_pkg::ADDR_CNT, 16'h0005);
		wr(t16w_pkg::ADDR_CMPA, 16'h0004);
		max_cnt(30, m);
		`CHK(m <= 16'h0007, 1'b1);
		max_cnt(20, m);
		`CHK(m, 16'h0004);
		wr(t16w_pkg::ADDR_CAP, 16'h0007);
		wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_FP_CAP, 2'h2, 2'h2, 3'h1));
		repeat (10) @(posedge i_clk);
		wr(t16w_pkg::ADDR_CNT, 16'h0005);
		wr(t16w_pkg::ADDR_CAP, 16'h0004);
		repeat (10) @(posedge i_clk);
		rd(t16w_pkg::ADDR_CNT, v);
		`CHK(v > 16'h0007, 1'b1);
	endtask : t_fast
	task automatic t_phase();
		wr(t16w_pkg::ADDR_CMPA, 16'h0003);
		wr(t16w_pkg::ADDR_CMPB, 16'h0001);
		for (int i = 0; i < 2; i++) begin
			wr(t16w_pkg::ADDR_CTRL, ctl(t16w_pkg::WGM_PC_A, 2'h2, 2'(2 + i), 3'h1));
			if (i == 0) wr(t16w_pkg::ADDR_CNT, 16'h0000);
			repeat (30) @(posedge i_clk);
			ones_b(60, k);
			`CHK(k, (i == 1) ? 40 : 20);
		end
		max_cnt(20, m);
		`CHK(m, 16'h0003);
		wr(t16w_pkg::ADDR_FLG, 16'h000f);
		repeat (12) @(posedge i_clk);
		rd(t16w_pkg::ADDR_FLG, v);
		`CHK(v[2:0], 3'h7);
	endtask : t_phase
	initial begin
		i_rst_b = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 3'h0;
		i_wdata = 16'h0000;
		err_total = 0;
		n_tests = 0;
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_reset();
		t_ctc();
		t_prescale();
		t_fast();
		t_phase();
		close_out();
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		err_total++;
		close_out();
	end
endmodule : t16w_timer_tb
bind t16w_timer t16w_timer_properties u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_pin_a(o_pin_a), .o_pin_a_oe_b(o_pin_a_oe_b), .o_pin_b(o_pin_b),
	.o_pin_b_oe_b(o_pin_b_oe_b));
`default_nettype wire
